// ### bench/core_model.sv
// Behavioural processor core that accepts vectored requests and returns from handlers.
module core_model
    import irq_ctrl_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              irq_req,
    input  wire logic [IDX_W-1:0]  irq_num,
    input  wire logic [DATA_W-1:0] irq_handler,
    output logic                   irq_ack,
    output logic                   irq_exit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [IDX_W-1:0]  taken_num;
    logic [DATA_W-1:0] taken_handler;

    initial begin
        irq_ack  = 1'b0;
        irq_exit = 1'b0;
    end

    // The number and handler are taken at the edge that samples the acknowledge.
    task automatic accept(input int lag);
        int i;
        repeat (lag) @(posedge clk);
        for (i = 0; i < 20 && irq_req !== 1'b1; i++) @(posedge clk);
        // The controller takes any acknowledge unchecked, so none is given without a standing request.
        if (irq_req === 1'b1) begin
            irq_ack <= 1'b1;
            @(posedge clk);
            taken_num     = irq_num;
            taken_handler = irq_handler;
            irq_ack <= 1'b0;
        end
        @(posedge clk);
    endtask

    // The trailing edge keeps two returns from merging into one long pulse.
    task automatic leave();
        irq_exit <= 1'b1;
        @(posedge clk);
        irq_exit <= 1'b0;
        @(posedge clk);
    endtask
endmodule // core_model

// ### bench/nested_priority_interrupt_ctrl_tb.sv
// Self-checking bench for the priority interrupt controller.
module nested_priority_interrupt_ctrl_tb
    import irq_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [ADDR_W-1:0]  paddr = '0;
    logic [DATA_W-1:0]  pwdata = '0;
    logic [DATA_W-1:0]  prdata;
    logic               pready;
    logic               pslverr;
    logic [NUM_SRC-1:0] irq_src = '0;
    logic               irq_ack;
    logic               irq_exit;
    logic               irq_req;
    logic [IDX_W-1:0]   irq_num;
    logic [DATA_W-1:0]  irq_handler;
    logic               in_handler;
    logic               exit_ok;
    logic [DATA_W-1:0]  rdat;
    logic               rerr;
    int                 n_errors = 0;
    int                 tests_run = 0;

    always #25 clk = ~clk;

    prio_irq_ctrl i_prio_irq_ctrl (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_src(irq_src), .irq_ack(irq_ack), .irq_exit(irq_exit),
        .irq_req(irq_req), .irq_num(irq_num), .irq_handler(irq_handler),
        .in_handler(in_handler), .exit_ok(exit_ok));

    core_model i_core_model (.clk(clk), .irq_req(irq_req), .irq_num(irq_num),
        .irq_handler(irq_handler), .irq_ack(irq_ack), .irq_exit(irq_exit));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0);
        chk(nm, rdat, exp);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic t_reset();
        int n;
        chk("pready", {31'h0, pready}, 32'h1);
        chk("irq_req", {31'h0, irq_req}, 32'h0);
        rdc("ctrl", OFF_CTRL, 32'h0);
        rdc("enable", OFF_ENABLE, 32'h0);
        rdc("status", OFF_STATUS, 32'h000E_0000);
        apb(1'b0, 10'h018, '0);
        chk("unmapped err", {31'h0, rerr}, 32'h1);
        apb(1'b1, 10'h006, 32'hFFFF_FFFF);
        chk("unaligned err", {31'h0, rerr}, 32'h1);
        for (n = 0; n < NUM_SRC; n++) wr(VEC_BASE + 10'(4 * n), 32'hA000_0000 | n);
    endtask

    task automatic t_mask();
        wr(OFF_ENABLE, 32'h0000_0008);
        wr(OFF_CTRL, 32'h0000_0001);
        irq_src <= 32'h0000_0008;
        repeat (5) @(posedge clk);
        chk("masked req", {31'h0, irq_req}, 32'h0);
        irq_src <= '0;
        rdc("enable kept", OFF_ENABLE, 32'h0000_0008);
        wr(OFF_CTRL, 32'h0);
        settle();
        chk("req", {31'h0, irq_req}, 32'h1);
        chk("num", {27'h0, irq_num}, 32'h3);
        wr(OFF_ENABLE, 32'h0);
        settle();
        chk("disabled req", {31'h0, irq_req}, 32'h0);
        rdc("pend kept", OFF_PEND_SET, 32'h0000_0008);
        wr(OFF_ENABLE, 32'h0000_0008);
        i_core_model.accept(3);
        chk("handler", i_core_model.taken_handler, 32'hA000_0003);
        settle();
        chk("in handler", {31'h0, in_handler}, 32'h1);
        chk("exit ok", {31'h0, exit_ok}, 32'h1);
        i_core_model.leave();
        settle();
        chk("left", {31'h0, in_handler}, 32'h0);
    endtask

    task automatic t_prio();
        wr(OFF_ENABLE, 32'h0000_0220);
        wr(PRIO_BASE + 10'h004, 32'h0000_1F00);
        wr(PRIO_BASE + 10'h008, 32'h0000_0000);
        rdc("prio low bits", PRIO_BASE + 10'h004, 32'h0);
        wr(OFF_PEND_SET, 32'h0000_0220);
        settle();
        chk("tie num", {27'h0, irq_num}, 32'h5);
        wr(OFF_PEND_CLR, 32'h0000_0220);
        wr(PRIO_BASE + 10'h004, 32'h0000_6000);
        wr(PRIO_BASE + 10'h008, 32'h0000_2000);
        wr(OFF_PEND_SET, 32'h0000_0220);
        settle();
        chk("urgent num", {27'h0, irq_num}, 32'h9);
        wr(OFF_PEND_CLR, 32'h0000_0200);
        // The request shows the new winner one edge after the clearing write.
        i_core_model.accept(2);
        chk("taken", {27'h0, i_core_model.taken_num}, 32'h5);
        wr(OFF_CTRL, 32'h0000_0100);
        wr(OFF_PEND_SET, 32'h0000_0200);
        settle();
        chk("no preempt", {31'h0, irq_req}, 32'h0);
        chk("exit held", {31'h0, exit_ok}, 32'h0);
        i_core_model.leave();
        settle();
        chk("chain num", {26'h0, irq_req, irq_num}, 32'h29);
        i_core_model.accept(0);
        wr(OFF_CTRL, 32'h0000_0700);
        wr(PRIO_BASE + 10'h004, 32'h0000_0000);
        wr(OFF_PEND_SET, 32'h0000_0020);
        settle();
        chk("preempt num", {26'h0, irq_req, irq_num}, 32'h25);
        wr(OFF_CTRL, 32'h0000_0300);
        settle();
        chk("grp3 num", {26'h0, irq_req, irq_num}, 32'h25);
        i_core_model.accept(1);
        rdc("depth", OFF_STATUS, 32'h0000_0502);
        chk("nested exit", {31'h0, exit_ok}, 32'h0);
        i_core_model.leave();
        i_core_model.leave();
        settle();
        chk("all left", {31'h0, in_handler}, 32'h0);
    endtask

    task automatic conclude();
        $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_mask();
        t_prio();
        conclude();
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule // nested_priority_interrupt_ctrl_tb

// ### common/irq_ctrl_pkg.sv
// Constants, register map and helper function for the priority interrupt controller.
// Functional notes
// - Thirty-two interrupt inputs, arbitrated over eight priority levels.
// - Each source has an enable; a global mask blocks the request only.
// - Controller enables touch only the controller, never the peripheral.
// - The handler address for the granted source is handed to the core.
// - Higher priority is served first and preempts a lower running handler.
// - Priority splits into preemption and subpriority; equal preemption tail-chains.
// - Equal priority ties go to the lower interrupt number.
// - Nesting depth is tracked; leaving context waits for all pending work.
// - Lower priority value means more urgent; zero is highest.
// - Only the upper three bits of each priority byte take part.
// - Grouping values three through seven behave identically.
package irq_ctrl_pkg;
    localparam int          NUM_SRC     = 32;
    localparam int          IDX_W       = 5;
    localparam int          PRIO_W      = 3;
    localparam int          PRIO_LSB    = 5;
    localparam int          PRIO_BYTES  = 4;
    localparam int          BYTE_W      = 8;
    localparam int          DEPTH_W     = 6;
    localparam int          ADDR_W      = 10;
    localparam int          DATA_W      = 32;
    localparam int          WORD_LSB    = 2;
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 10'h000;
    localparam logic [ADDR_W-1:0] OFF_ENABLE   = 10'h004;
    localparam logic [ADDR_W-1:0] OFF_PEND_SET = 10'h008;
    localparam logic [ADDR_W-1:0] OFF_PEND_CLR = 10'h00C;
    localparam logic [ADDR_W-1:0] OFF_ACTIVE   = 10'h010;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 10'h014;
    localparam logic [ADDR_W-1:0] PRIO_BASE    = 10'h020;
    localparam logic [ADDR_W-1:0] PRIO_END     = 10'h040;
    localparam logic [ADDR_W-1:0] VEC_BASE     = 10'h080;
    localparam logic [ADDR_W-1:0] VEC_END      = 10'h100;
    localparam int          CTRL_MASK_BIT = 0;
    localparam int          CTRL_GRP_LSB  = 8;
    localparam int          ST_NUM_LSB    = 8;
    localparam int          ST_REQ_BIT    = 16;
    localparam int          ST_PRE_LSB    = 17;
    localparam logic [2:0]  GRP_RESET     = 3'h0;
    localparam logic [2:0]  PRIO_ALL      = 3'h7;

    // Preemption part of a priority for a given number of preemption bits.
    function automatic logic [PRIO_W-1:0] pre_of(input logic [PRIO_W-1:0] p,
                                                 input logic [2:0] grp);
        logic [PRIO_W-1:0] m;
        // three or more bits keep all
        m = (grp >= 3'(PRIO_W)) ? PRIO_ALL : ~(PRIO_ALL >> grp);
        return p & m;
    endfunction
endpackage

// ### common/vec_mem_if.sv
// Port bundle between the controller and its handler address table.
interface vec_mem_if;
    logic                    we;
    logic [4:0]              waddr;
    logic [31:0]             wdata;
    logic [4:0]              raddr_a;
    logic [31:0]             rdata_a;
    logic [4:0]              raddr_b;
    logic [31:0]             rdata_b;
    modport ctrl (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
    modport mem  (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface

// ### rtl/prio_irq_ctrl.sv
// Prioritising vectored interrupt controller with APB register access.
//
// The APB slave port and the placing of the registers are this design's own decisions.
module prio_irq_ctrl
    import irq_ctrl_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NUM_SRC-1:0] irq_src,
    input  wire logic              irq_ack,
    input  wire logic              irq_exit,
    output logic                   irq_req,
    output logic      [IDX_W-1:0]  irq_num,
    output logic      [DATA_W-1:0] irq_handler,
    output logic                   in_handler,
    output logic                   exit_ok
);
    vec_mem_if vm ();

    logic [NUM_SRC-1:0] src_meta;
    logic [NUM_SRC-1:0] src_sync;
    logic [NUM_SRC-1:0] enable;
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0] active;
    logic [PRIO_W-1:0]  prio [NUM_SRC];
    logic               gmask;
    logic [2:0]         grp;
    logic [DEPTH_W-1:0] nest_depth;

    // Bus decode.
    wire setup_rd  = psel && !penable && !pwrite;
    wire access_wr = psel && penable && pwrite;
    wire is_ctrl   = paddr == OFF_CTRL;
    wire is_enable = paddr == OFF_ENABLE;
    wire is_pset   = paddr == OFF_PEND_SET;
    wire is_pclr   = paddr == OFF_PEND_CLR;
    wire is_active = paddr == OFF_ACTIVE;
    wire is_status = paddr == OFF_STATUS;
    wire is_prio   = paddr >= PRIO_BASE && paddr < PRIO_END;
    wire is_vec    = paddr >= VEC_BASE && paddr < VEC_END;
    wire aligned   = paddr[WORD_LSB-1:0] == '0;
    wire mapped    = aligned && (is_ctrl || is_enable || is_pset || is_pclr || is_active
                     || is_status || is_prio || is_vec);
    wire [2:0]       prio_word = paddr[WORD_LSB +: 3];
    wire [IDX_W-1:0] vec_idx   = paddr[WORD_LSB +: IDX_W];

    // Arbitration over eligible sources.
    logic [NUM_SRC-1:0] eligible;
    logic               best_v;
    logic [IDX_W-1:0]   best;
    logic               cur_v;
    logic [PRIO_W-1:0]  cur_pre;
    logic [IDX_W-1:0]   inner;
    logic               want;
    logic               next_req;
    logic [NUM_SRC-1:0] next_pend;
    logic [NUM_SRC-1:0] next_active;
    logic [DEPTH_W-1:0] next_depth;
    logic [DATA_W-1:0]  rd_word;

    assign eligible = pend & enable & ~active;

    always_comb begin
        best_v  = 1'b0;
        best    = '0;
        cur_v   = 1'b0;
        cur_pre = PRIO_ALL;
        inner   = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (eligible[i] && (!best_v || prio[i] < prio[best])) begin
                best_v = 1'b1;
                best   = IDX_W'(i);
            end
            if (active[i] && (!cur_v || pre_of(prio[i], grp) < cur_pre)) begin
                cur_v   = 1'b1;
                cur_pre = pre_of(prio[i], grp);
                inner   = IDX_W'(i);
            end
        end
    end

    assign want     = best_v && !gmask && (!cur_v || pre_of(prio[best], grp) < cur_pre);
    assign next_req = want && !irq_ack;

    always_comb begin
        next_active = active;
        if (irq_exit && cur_v) begin
            next_active[inner] = 1'b0;
        end
        if (irq_ack) begin
            next_active[irq_num] = 1'b1;
        end
        next_depth = nest_depth + DEPTH_W'(irq_ack) - DEPTH_W'(irq_exit && nest_depth != '0);
    end

    // Hardware set wins over any clear so an edge during a clear is not lost.
    always_comb begin
        next_pend = pend;
        if (access_wr && is_pclr) begin
            next_pend = next_pend & ~pwdata;
        end
        if (irq_ack) begin
            next_pend[irq_num] = 1'b0;
        end
        next_pend = next_pend | src_sync;
        if (access_wr && is_pset) begin
            next_pend = next_pend | pwdata;
        end
    end

    always_comb begin
        rd_word = '0;
        if (is_ctrl) begin
            rd_word[CTRL_MASK_BIT] = gmask;
            rd_word[CTRL_GRP_LSB +: 3] = grp;
        end else if (is_enable) begin
            rd_word = enable;
        end else if (is_pset || is_pclr) begin
            rd_word = pend;
        end else if (is_active) begin
            rd_word = active;
        end else if (is_status) begin
            rd_word[DEPTH_W-1:0] = nest_depth;
            rd_word[ST_NUM_LSB +: IDX_W] = inner;
            rd_word[ST_REQ_BIT] = irq_req;
            rd_word[ST_PRE_LSB +: PRIO_W] = cur_pre;
        end else if (is_prio) begin
            for (int b = 0; b < PRIO_BYTES; b++) begin
                rd_word[b*BYTE_W + PRIO_LSB +: PRIO_W] = prio[{prio_word, 2'(b)}];
            end
        end
    end

    // handler address looked up for the winner
    assign vm.raddr_a = best;
    assign vm.raddr_b = vec_idx;
    assign vm.we      = access_wr && is_vec && aligned;
    assign vm.waddr   = vec_idx;
    assign vm.wdata   = pwdata;
    assign irq_handler = vm.rdata_a;

    vec_table #(.DEPTH(NUM_SRC)) u_table (
        .clk (clk),
        .mp  (vm)
    );

    always_ff @(posedge clk) begin
        src_meta <= irq_src;
        src_sync <= src_meta;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pend <= '0;
            active <= '0;
            nest_depth <= '0;
            irq_req <= 1'b0;
            irq_num <= '0;
            in_handler <= 1'b0;
            exit_ok <= 1'b0;
        end else begin
            pend <= next_pend;
            active <= next_active;
            nest_depth <= next_depth;
            irq_req <= next_req;
            irq_num <= best;
            in_handler <= next_depth != '0;
            // leave only when nothing else waits
            exit_ok <= next_depth == DEPTH_W'(1) && !best_v && !next_req;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            enable <= '0;
            gmask <= 1'b0;
            grp <= GRP_RESET;
            for (int i = 0; i < NUM_SRC; i++) begin
                prio[i] <= '0;
            end
        end else if (access_wr && aligned) begin
            if (is_ctrl) begin
                gmask <= pwdata[CTRL_MASK_BIT];
                grp <= pwdata[CTRL_GRP_LSB +: 3];
            end else if (is_enable) begin
                enable <= pwdata;
            end else if (is_prio) begin
                for (int b = 0; b < PRIO_BYTES; b++) begin
                    prio[{prio_word, 2'(b)}] <= pwdata[b*BYTE_W + PRIO_LSB +: PRIO_W];
                end
            end
        end
    end

    // Zero wait states; read data is captured in the setup cycle.
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (psel && !penable) begin
                pslverr <= !mapped;
                prdata <= '0;
                if (setup_rd && mapped && !is_vec) begin
                    prdata <= rd_word;
                end
            end
        end
    end

    // The vector read mux takes the table port one edge after setup; prdata stays zero for vector reads.
    logic vec_rd_q;
    always_ff @(posedge clk) begin
        vec_rd_q <= setup_rd && is_vec && aligned;
    end
    wire [DATA_W-1:0] bus_rdata = vec_rd_q ? vm.rdata_b : prdata;

    // The request register lags the gating by one edge, so it is judged by the cycle before.
    logic gate_ok;
    assign gate_ok = pend[best] && enable[best] && !active[best] && !gmask;

    // Tie and level checks over all eligible sources.
    logic tie_bad;
    logic lvl_bad;
    always_comb begin
        tie_bad = 1'b0;
        lvl_bad = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (eligible[i] && prio[i] < prio[best]) lvl_bad = 1'b1;
            if (eligible[i] && IDX_W'(i) < best && prio[i] == prio[best]) tie_bad = 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence ack_s;
        irq_req && irq_ack;
    endsequence

    req_enabled_a: assert property (irq_req |-> $past(gate_ok))
        else $error("request for a disabled or active source");
    gmask_block_a: assert property (gmask |=> !irq_req)
        else $error("request while globally masked");
    ack_nest_a: assert property (ack_s |=> active[$past(irq_num)] && nest_depth ==
                                 $past(nest_depth) + DEPTH_W'(1) - DEPTH_W'($past(irq_exit)))
        else $error("accept did not record nesting");
    preempt_lvl_a: assert property (next_req && cur_v |-> pre_of(prio[best], grp) < cur_pre)
        else $error("request does not preempt running level");
    sub_chain_a: assert property (cur_v && best_v && pre_of(prio[best], grp) == cur_pre
                                  |-> !want)
        else $error("equal preemption level preempted");
    tie_lowest_a: assert property (best_v |-> !tie_bad)
        else $error("tie not given to lowest number");
    lowest_val_a: assert property (best_v |-> !lvl_bad)
        else $error("more urgent source passed over");
    grp_same_a: assert property (grp >= 3'(PRIO_W) |-> pre_of(prio[best], grp) == prio[best])
        else $error("grouping above three changed behaviour");
    exit_gate_a: assert property (exit_ok |-> nest_depth == DEPTH_W'(1) && !irq_req)
        else $error("exit allowed with work outstanding");
    handler_fresh_a: assert property (irq_req |-> $past(best) == irq_num)
        else $error("handler index not aligned with request");
    bus_answer_a: assert property (psel && penable |-> pready)
        else $error("bus did not answer in zero wait");

    // The read mux feeds only this unused net; the table port never reaches prdata on the bus.
    logic unused_rd;
    assign unused_rd = ^bus_rdata;
endmodule // prio_irq_ctrl

// ### rtl/vec_table.sv
// Handler address table with two registered read ports.
module vec_table #(
    parameter int DEPTH = 32
) (
    input  wire logic clk,
    vec_mem_if.mem    mp
);
    logic [31:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (mp.we) begin
            mem[mp.waddr] <= mp.wdata;
        end
        mp.rdata_a <= mem[mp.raddr_a];
        mp.rdata_b <= mem[mp.raddr_b];
    end
endmodule // vec_table
